/* common/acs_pkg.sv */
package acs_pkg;
    // register byte addresses
    localparam logic [7:0]  ADDR_SEQUENCER_CONTROL     = 8'h22;
    localparam logic [7:0]  ADDR_AUTOCYCLE_CONTROL      = 8'h23;
    localparam logic [7:0]  ADDR_CHAN_MASK_LO = 8'h24;
    localparam logic [7:0]  ADDR_CHAN_MASK_HI = 8'h25;
    // reset values
    localparam logic [7:0]  RST_SEQUENCER_CONTROL      = 8'h80;
    localparam logic [7:0]  RST_AUTOCYCLE_CONTROL       = 8'h00;
    localparam logic [15:0] RST_CHAN_MASK     = 16'h0001;
    // field positions
    localparam int          SEQ_STD_ON_BIT    = 7;
    localparam int          SEQ_SLOT_MSB      = 6;
    localparam int          AC_ON_BIT         = 0;
    localparam int          AC_SEL_LSB        = 1;
    localparam int          AC_SEL_MSB        = 3;
    localparam logic [7:0]  AC_WR_MASK        = 8'h0F;
    // timing: period per select code, in microseconds
    localparam int          CLK_MHZ           = 25;
    localparam int          PER_W             = 15;
    localparam int          PERIOD_US [8]     = '{10, 20, 40, 80, 100, 200, 400, 800};
    localparam logic [PER_W-1:0] PER_CYC_0    = PER_W'(PERIOD_US[0] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_1    = PER_W'(PERIOD_US[1] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_2    = PER_W'(PERIOD_US[2] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_3    = PER_W'(PERIOD_US[3] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_4    = PER_W'(PERIOD_US[4] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_5    = PER_W'(PERIOD_US[5] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_6    = PER_W'(PERIOD_US[6] * CLK_MHZ);
    localparam logic [PER_W-1:0] PER_CYC_7    = PER_W'(PERIOD_US[7] * CLK_MHZ);
endpackage

/* common/acs_tmr_if.sv */
`timescale 1ns/100ps
// control path between register file and period timer
interface acs_tmr_if;
    logic       en;   // autocycle running
    logic [2:0] sel;  // period select code
    logic       tick; // one-cycle period pulse
    modport ctl (output en, output sel, input tick);
    modport tmr (input en, input sel, output tick);
endinterface

/* hdl/acs_period_timer.sv */
`timescale 1ns/100ps
module acs_period_timer import acs_pkg::*; #(
    parameter logic [7:0][PER_W-1:0] PERIODS = {PER_CYC_7, PER_CYC_6, PER_CYC_5, PER_CYC_4,
                                                PER_CYC_3, PER_CYC_2, PER_CYC_1, PER_CYC_0}
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    // control from register file
    acs_tmr_if.tmr    t
);
    typedef struct packed {
        logic [PER_W-1:0] cnt;   // cycles into current period
        logic [2:0]       sel_d; // select seen last cycle
        logic             tick;  // period pulse
    } acs_tmr_s;

    acs_tmr_s st_r;   // registered state
    acs_tmr_s st_nxt; // next state

    // count periods; any select change restarts so no odd-length period is emitted
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sel_d = t.sel;
        st_nxt.tick  = 1'b0;
        if (!t.en || t.sel != st_r.sel_d) begin
            st_nxt.cnt = '0; // stopped or retimed
        end else if (st_r.cnt == PER_W'(PERIODS[t.sel] - 1'b1)) begin
            st_nxt.cnt  = '0; // period selected by code
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = PER_W'(st_r.cnt + 1'b1);
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign t.tick = st_r.tick;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_TMR_SILENT_OFF: assert property (!$past(t.en) |-> !t.tick)
        else $error("timer ticked while autocycle off");
endmodule

/* hdl/acs_seq_config.sv */
`timescale 1ns/100ps
// Behaviour
// - bit 7 enables standard sequencer, resets set
// - advanced sequence length is slot field plus one
// - period code selects 10 to 800 us
// - autocycle bit starts and stops internal converts
// - mask bit n includes channel n
// - mask resets to channel 0 only
// - autocycle register resets to zero
module acs_seq_config import acs_pkg::*; #(
    // long periods, shortenable for simulation
    parameter logic [PER_W-1:0] PERIOD_CYC_200US = PER_CYC_5,
    parameter logic [PER_W-1:0] PERIOD_CYC_400US = PER_CYC_6,
    parameter logic [PER_W-1:0] PERIOD_CYC_800US = PER_CYC_7
) (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    // register access
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // external convert request
    input  wire logic       cnv_req_i,
    // to conversion core
    output logic            conv_start_o,
    output logic      [2:0] conv_chan_o,
    output logic            std_seq_on_o,
    output logic      [7:0] slot_total_o,
    output logic            auto_on_o,
    output logic      [7:0] chan_mask_o
);
    typedef struct packed {
        logic [7:0] sequencer_control;   // sequencer control
        logic [7:0] autocycle_control;    // autocycle control, low nibble only
        logic [7:0] chan_mask;  // channel inclusion
        logic [7:0] slot_total; // slots in advanced sequence
        logic [2:0] chan;       // next candidate channel
        logic [2:0] conv_chan;  // channel of last start
        logic       conv_start; // start pulse
        logic [7:0] rdata;      // read data
    } acs_cfg_s;

    acs_cfg_s st_r;   // registered state
    acs_cfg_s st_nxt; // next state

    acs_tmr_if tmr_if (); // timer control

    // first included channel at or after a start point, wrapping upward
    function automatic logic [2:0] sel_chan(input logic [7:0] m, input logic [2:0] from);
        logic [2:0] idx;
        sel_chan = from;
        for (int i = 7; i >= 0; i--) begin
            idx = 3'(from + 3'(i));
            if (m[idx]) begin
                sel_chan = idx; // lowest offset wins
            end
        end
    endfunction

    // cycles per period code, long codes take module parameters
    localparam logic [7:0][PER_W-1:0] PER_TAB = {PERIOD_CYC_800US, PERIOD_CYC_400US, PERIOD_CYC_200US, PER_CYC_4,
                                                 PER_CYC_3, PER_CYC_2, PER_CYC_1, PER_CYC_0};

    // period timer
    acs_period_timer #(
        .PERIODS (PER_TAB)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .t         (tmr_if.tmr)
    );

    assign tmr_if.en  = st_r.autocycle_control[AC_ON_BIT];
    assign tmr_if.sel = st_r.autocycle_control[AC_SEL_MSB:AC_SEL_LSB];

    // register writes, reads and channel stepping
    always_comb begin
        logic       start;
        logic [2:0] pick;
        start  = 1'b0;
        pick   = 3'h0;
        st_nxt = st_r;
        // writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_SEQUENCER_CONTROL:     st_nxt.sequencer_control  = reg_wdata_i;
                ADDR_AUTOCYCLE_CONTROL:      st_nxt.autocycle_control   = reg_wdata_i & AC_WR_MASK;
                ADDR_CHAN_MASK_LO: st_nxt.chan_mask = reg_wdata_i;
                default:           st_nxt.sequencer_control  = st_r.sequencer_control;           // high byte and others ignored
            endcase
        end
        // sequence length follows the slot field
        st_nxt.slot_total = 8'({1'b0, st_nxt.sequencer_control[SEQ_SLOT_MSB:0]} + 8'h01);
        // reads; reserved space reads zero
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_SEQUENCER_CONTROL:     st_nxt.rdata = st_r.sequencer_control;
                ADDR_AUTOCYCLE_CONTROL:      st_nxt.rdata = st_r.autocycle_control;
                ADDR_CHAN_MASK_LO: st_nxt.rdata = st_r.chan_mask;
                default:           st_nxt.rdata = 8'h00;
            endcase
        end
        // a start comes from the timer only while autocycle is on
        start = (tmr_if.tick && st_r.autocycle_control[AC_ON_BIT]) || cnv_req_i;
        st_nxt.conv_start = start;
        if (start) begin
            if (st_r.sequencer_control[SEQ_STD_ON_BIT]) begin
                // pick from mask, candidate rechecked in case the mask changed
                pick              = sel_chan(st_r.chan_mask, st_r.chan);
                st_nxt.conv_chan  = pick;
                st_nxt.chan       = 3'(pick + 3'h1);
            end else begin
                st_nxt.conv_chan  = st_r.chan; // held while standard sequencer off
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r.sequencer_control   <= RST_SEQUENCER_CONTROL;
            st_r.autocycle_control    <= RST_AUTOCYCLE_CONTROL;
            st_r.chan_mask  <= RST_CHAN_MASK[7:0];
            st_r.slot_total <= 8'h01;
            st_r.chan       <= 3'h0;
            st_r.conv_chan  <= 3'h0;
            st_r.conv_start <= 1'b0;
            st_r.rdata      <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o  = st_r.rdata;
    assign conv_start_o = st_r.conv_start;
    assign conv_chan_o  = st_r.conv_chan;
    assign std_seq_on_o = st_r.sequencer_control[SEQ_STD_ON_BIT];
    assign slot_total_o = st_r.slot_total;
    assign auto_on_o    = st_r.autocycle_control[AC_ON_BIT];
    assign chan_mask_o  = st_r.chan_mask;

    // checking helpers: gap between starts and channel of last start
    logic [PER_W:0] gap_q;       // cycles since last start
    logic [2:0]     last_q;      // channel of last start
    logic           seen_q;      // last start was sequenced from the mask
    logic           std_q;       // sequencer enable one cycle back
    logic           tmr_start_q; // start now showing came from the timer alone
    logic           chain_q;     // last start timed, setting steady since
    logic [2:0]     sel_q;       // period select one cycle back
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_q       <= '0;
            last_q      <= 3'h0;
            seen_q      <= 1'b0;
            std_q       <= 1'b0;
            tmr_start_q <= 1'b0;
            chain_q     <= 1'b0;
            sel_q       <= 3'h0;
        end else begin
            gap_q       <= conv_start_o ? (PER_W+1)'(1) : (PER_W+1)'(gap_q + 1'b1);
            // enable as it stood when the showing start was picked
            std_q       <= std_seq_on_o;
            seen_q      <= conv_start_o ? std_q : seen_q;
            last_q      <= conv_start_o ? conv_chan_o : last_q;
            tmr_start_q <= tmr_if.tick && auto_on_o && !cnv_req_i;
            sel_q       <= tmr_if.sel;
            // any select change or stop restarts the timer, so the chain breaks
            chain_q     <= (conv_start_o ? tmr_start_q : chain_q) && auto_on_o && (tmr_if.sel == sel_q);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_STD_WRITE: assert property (reg_wr_i && reg_addr_i == ADDR_SEQUENCER_CONTROL
        |=> std_seq_on_o == $past(reg_wdata_i[SEQ_STD_ON_BIT]))
        else $error("standard sequencer enable did not follow write");
    AST_STD_RST: assert property (@(posedge ref_clk_i) $rose(nrst_i) |-> std_seq_on_o)
        else $error("standard sequencer not on after reset");
    AST_SLOT_LEN: assert property (reg_wr_i && reg_addr_i == ADDR_SEQUENCER_CONTROL
        |=> slot_total_o == 8'({1'b0, $past(reg_wdata_i[SEQ_SLOT_MSB:0])} + 8'h01))
        else $error("slot total is not field plus one");
    AST_AUTO_PERIOD: assert property (conv_start_o && tmr_start_q && chain_q
        |-> gap_q == (PER_W+1)'(PER_TAB[tmr_if.sel]))
        else $error("autocycle period wrong for selected code");
    AST_AUTO_STOP: assert property (!$past(auto_on_o) && !$past(cnv_req_i) |-> !conv_start_o)
        else $error("start issued with autocycle off");
    AST_CHAN_INCL: assert property (conv_start_o && $past(std_seq_on_o) && $past(chan_mask_o) != 8'h00
        |-> (($past(chan_mask_o) >> conv_chan_o) & 8'h01) != 8'h00)
        else $error("converted channel not included");
    AST_MASK_RST: assert property (@(posedge ref_clk_i) $rose(nrst_i) |-> chan_mask_o == RST_CHAN_MASK[7:0])
        else $error("channel mask wrong after reset");
    AST_AC_RST: assert property (@(posedge ref_clk_i) $rose(nrst_i) |-> !auto_on_o && reg_rdata_o == 8'h00)
        else $error("autocycle not cleared by reset");
    AST_ASCEND: assert property (conv_start_o && std_seq_on_o && $stable(chan_mask_o)
        && $past(std_seq_on_o) && seen_q && $past(chan_mask_o) == chan_mask_o
        |-> conv_chan_o == sel_chan(chan_mask_o, 3'(last_q + 3'h1)))
        else $error("channel order not ascending");
    AST_RSVD_ZERO: assert property (reg_rd_i && reg_addr_i == ADDR_CHAN_MASK_HI |=> reg_rdata_o == 8'h00)
        else $error("reserved byte read non-zero");
    AST_AC_HI_ZERO: assert property (reg_rd_i && reg_addr_i == ADDR_AUTOCYCLE_CONTROL
        |=> reg_rdata_o[7:4] == 4'h0)
        else $error("reserved autocycle bits stored");

    COV_AUTO_START: cover property (auto_on_o ##[1:1000] conv_start_o);
    COV_WRAP: cover property (conv_start_o && conv_chan_o < last_q && seen_q);
    COV_STD_OFF: cover property (!std_seq_on_o && conv_start_o);
endmodule

/* tb/acs_host.sv */
`timescale 1ns/100ps
// host controller model driving the register strobe port
module acs_host (
    // clock
    input  wire logic       ref_clk_i,
    // register port towards the device
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    // idle bus at time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end
    // one write strobe; released lines are inverted so stale data never looks valid;
    // returns one edge after the strobe edge so the caller sees settled outputs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
        @(posedge ref_clk_i);
    endtask
    // one read strobe; data is taken at the edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge ref_clk_i);
        d = reg_rdata_i;
    endtask
endmodule

/* tb/adc_channel_sequencer_config_bench.sv */
`timescale 1ns/100ps
module adc_channel_sequencer_config_bench import acs_pkg::*;;
    // shortened long periods, in cycles
    localparam logic [PER_W-1:0] P5 = 15'h0028;
    localparam logic [PER_W-1:0] P6 = 15'h003C;
    localparam logic [PER_W-1:0] P7 = 15'h0050;
    logic       ref_clk_i, nrst_i, cnv_req_i, reg_wr, reg_rd, conv_start, std_on, auto_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, slot_total, chan_mask, rv, msk, v;
    logic [2:0] conv_chan;
    logic [31:0] lfsr;
    int         mismatches, compares, cur, cand, n, seq_on;
    int         per [8];
    acs_host acs_host_inst (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
    acs_seq_config #(.PERIOD_CYC_200US(P5), .PERIOD_CYC_400US(P6), .PERIOD_CYC_800US(P7)) acs_seq_config_inst (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .cnv_req_i(cnv_req_i),
        .conv_start_o(conv_start), .conv_chan_o(conv_chan), .std_seq_on_o(std_on),
        .slot_total_o(slot_total), .auto_on_o(auto_on), .chan_mask_o(chan_mask));
    // free-running clock, 40 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // pseudo-random source, fixed start
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // model: lowest included channel at or above the candidate, wrapping, then the
    // candidate moves past it; empty mask reports the candidate; sequencer off holds it
    task automatic step();
        cur = cand;
        if (seq_on != 0) begin
            for (int k = 0; k < 8; k++) begin
                if (msk[(cand + k) % 8]) begin
                    cur = (cand + k) % 8;
                    break;
                end
            end
            cand = (cur + 1) % 8;
        end
    endtask
    // bounded wait for a convert start, returns cycles waited
    task automatic wait_start(output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk_i);
            cnt++;
        end while (conv_start !== 1'b1 && cnt < 3000);
        if (cnt >= 3000) begin
            mismatches++;
            stop_test();
        end else begin
            step();
            chk(16'(conv_chan), 16'(cur));
        end
    endtask
    initial begin
        nrst_i = 1'b0;
        cnv_req_i = 1'b0;
        lfsr = 32'h747CBFDC;
        mismatches = 0;
        compares = 0;
        cur = 0;
        cand = 0;
        seq_on = 1;
        msk = 8'h01;
        for (int c = 0; c < 8; c++) per[c] = (c < 5) ? PERIOD_US[c] * CLK_MHZ : (c == 5 ? P5 : (c == 6 ? P6 : P7));
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        // reset state
        chk(std_on, 1'b1);
        chk(chan_mask, 8'h01);
        acs_host_inst.rd(8'h22, rv);
        chk(rv, 8'h80);
        acs_host_inst.rd(8'h23, rv);
        chk({auto_on, rv}, 9'h000);
        // reserved bits, reserved byte and unmapped place
        acs_host_inst.wr(8'h23, 8'hF0);
        acs_host_inst.wr(8'h25, 8'hFF);
        acs_host_inst.wr(8'h40, 8'h5A);
        acs_host_inst.rd(8'h23, rv);
        chk({auto_on, rv}, 9'h000);
        acs_host_inst.rd(8'h25, rv);
        chk(rv, 8'h00);
        acs_host_inst.rd(8'h40, rv);
        chk(rv, 8'h00);
        // slot count field, boundaries then random
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h7F : ((i == 1) ? 8'h00 : rnd());
            v[7] = 1'b0;
            acs_host_inst.wr(8'h22, {1'b1, v[6:0]});
            chk(slot_total, v + 8'h01);
            acs_host_inst.rd(8'h22, rv);
            chk(rv, {1'b1, v[6:0]});
        end
        // channel mask rounds with back-to-back requests; last round sequencer off
        for (int r = 0; r < 5; r++) begin
            msk = (r == 3) ? 8'h00 : rnd();
            acs_host_inst.wr(8'h24, msk);
            chk(chan_mask, msk);
            acs_host_inst.rd(8'h24, rv);
            chk(rv, msk);
            if (r == 4) begin
                seq_on = 0;
                acs_host_inst.wr(8'h22, 8'h00);
                chk(std_on, 1'b0);
            end
            cnv_req_i <= 1'b1;
            for (int j = 0; j < 11; j++) begin
                @(posedge ref_clk_i);
                if (j == 9) cnv_req_i <= 1'b0;
                if (j > 0) begin
                    step();
                    chk({conv_start, 5'h00, conv_chan}, {1'b1, 5'h00, 3'(cur)});
                end
            end
            @(posedge ref_clk_i);
            chk(conv_start, 1'b0);
        end
        seq_on = 1;
        acs_host_inst.wr(8'h22, 8'h80);
        msk = 8'hFF;
        acs_host_inst.wr(8'h24, msk);
        // every period code: interval between internal starts
        for (int c = 0; c < 8; c++) begin
            acs_host_inst.wr(8'h23, {4'h0, 3'(c), 1'b1});
            chk(auto_on, 1'b1);
            wait_start(n);
            wait_start(n);
            chk(16'(n), 16'(per[c]));
        end
        // autocycle off: no further starts
        acs_host_inst.wr(8'h23, 8'h0E);
        acs_host_inst.rd(8'h23, rv);
        chk({auto_on, rv}, 9'h00E);
        n = 0;
        repeat (200) begin
            @(posedge ref_clk_i);
            if (conv_start === 1'b1) n++;
        end
        chk(16'(n), 16'h0000);
        stop_test();
    end
endmodule
